// ===== inc/vdtb_pkg.sv
/*
 Package for the data transfer bus handshake: address modifier codes,
 width options, transfer sizes and time-out figures.
 Assumes a single 20 MHz system clock shared by both ends.
*/
`default_nettype none
package vdtb_pkg;
   // ------------------------------------------------------------
   // Clock and time-out
   // ------------------------------------------------------------
   localparam int CLK_HZ          = 20000000;
   localparam int BTO_US_DEF      = 64;
   localparam int BTO_CYC_DEF     = BTO_US_DEF * (CLK_HZ / 1000000);
   localparam int BTO_CW          = 16;

   // ------------------------------------------------------------
   // Address modifier codes
   // ------------------------------------------------------------
   localparam logic [5:0] AM_STD_SUP_SEQ = 6'h3F;
   localparam logic [5:0] AM_STD_NP_SEQ  = 6'h3B;
   localparam logic [5:0] AM_EXT_SUP_SEQ = 6'h0F;
   localparam logic [5:0] AM_EXT_NP_SEQ  = 6'h0B;
   localparam logic [5:0] AM_SHORT_SUP   = 6'h2D;
   localparam logic [5:0] AM_SHORT_NP    = 6'h29;
   localparam logic [5:0] AM_STD_NP_DATA = 6'h39;

   // ------------------------------------------------------------
   // Option encodings
   // ------------------------------------------------------------
   localparam logic [1:0] DW_D8  = 2'h0;
   localparam logic [1:0] DW_D16 = 2'h1;
   localparam logic [1:0] DW_D32 = 2'h2;
   localparam logic [1:0] AW_A16 = 2'h0;
   localparam logic [1:0] AW_A24 = 2'h1;
   localparam logic [1:0] AW_A32 = 2'h2;

   // Transfer sizes
   localparam logic [1:0] SZ_BYTE = 2'h0;
   localparam logic [1:0] SZ_WORD = 2'h1;
   localparam logic [1:0] SZ_LONG = 2'h2;

   // Address bits per range (A01 upward)
   localparam int A16_MSB = 15;
   localparam int A24_MSB = 23;
   localparam int A32_MSB = 31;

   // Address step per transfer size
   localparam logic [31:0] STEP_BYTE = 32'h0000_0001;
   localparam logic [31:0] STEP_WORD = 32'h0000_0002;
   localparam logic [31:0] STEP_LONG = 32'h0000_0004;

   // ------------------------------------------------------------
   // Address range class of a modifier code
   // ------------------------------------------------------------
   function automatic logic [1:0] vdtb_am_range(input logic [5:0] am);
      logic [1:0] r;
      r = AW_A32;
      if (am[5:4] == 2'h2) begin
         r = AW_A16;
      end else if (am[5:4] == 2'h3) begin
         r = AW_A24;
      end
      return r;
   endfunction : vdtb_am_range

   function automatic logic vdtb_am_seq(input logic [5:0] am);
      return (am == AM_STD_SUP_SEQ) || (am == AM_STD_NP_SEQ) ||
             (am == AM_EXT_SUP_SEQ) || (am == AM_EXT_NP_SEQ);
   endfunction : vdtb_am_seq
endpackage : vdtb_pkg
`default_nettype wire

// ===== inc/vdtb_if.sv
/*
 Interface carrying the data transfer bus between master and slave ends.
 Strobes are active low; data, acknowledge and error have enables,
 the bench resolves the wired levels.
*/
`default_nettype none
interface vdtb_if;
   logic [31:1] addr;
   logic [5:0]  am;
   logic        as_n;
   logic        ds0_n;
   logic        ds1_n;
   logic        lword_n;
   logic        write_n;
   logic [31:0] m_data_o;
   logic        m_data_oe;
   logic [31:0] s_data_o;
   logic        s_data_oe;
   logic [31:0] data_i;
   logic        dtack_n_o;
   logic        dtack_oe;
   logic        berr_n_o;
   logic        berr_oe;
   logic        dtack_n;
   logic        berr_n;

   modport master (
      output addr, am, as_n, ds0_n, ds1_n, lword_n, write_n, m_data_o, m_data_oe,
      input  data_i, dtack_n, berr_n
   );
   modport slave (
      input  addr, am, as_n, ds0_n, ds1_n, lword_n, write_n, data_i,
      output s_data_o, s_data_oe, dtack_n_o, dtack_oe, berr_n_o, berr_oe
   );
endinterface : vdtb_if
`default_nettype wire

// ===== hw/vdtb_slave.sv
/*
 Slave end of the data transfer bus: address and modifier decode,
 acknowledge or bus error, sequential address counter, local memory.
 Assumes the bus inputs are synchronous to sys_clk.
*/
// Functional notes
// R1: D8 slave moves one byte on D00-D07; this slave moves even bytes on D08-D15
// R2: D8 master uses D00-D15, one byte each
// R3: D16 limits transfers to byte or word
// R4: D32 supports longword transfers
// R5: A16 master drives short codes, 15 bits
// R6: A16 slave decodes A01-A15, short codes only
// R7: A24 limits to 23 bits, A32 to 31
// R8: Time-out aborts unanswered cycle
// R9: SEQ master requests, slave answers sequential
// R10: Master starts, slave acknowledges, master ends
// R11: Master drives all six modifier lines
// R12: Addresses start at A01, strobes pick bytes
// R13: Master presents address, then drops strobes
// R14: Owning slave checks, gives data, acknowledges
// R15: Illegal access gets bus error; others silent
// R16: Master waits, captures data, releases strobes
// R17: Slave releases data, then its response
// R18: Bus error starts error handling
// R19: Sequential codes load and advance counter
// R20: Slave ignores codes not configured
// R21: Sequential codes 3F, 3B, 0F, 0B
// R22: Short ignores A16-A31, standard A24-A31
// R23: Time-out counts cycles, signals bus error
`default_nettype none
module vdtb_slave #(
   parameter logic [1:0]  DW       = vdtb_pkg::DW_D32,
   parameter logic [1:0]  AW       = vdtb_pkg::AW_A24,
   parameter logic        SEQ_EN   = 1'b1,
   parameter int          MEM_AW   = 8,
   parameter logic [31:0] BASE     = 32'h0000_0000
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   vdtb_if.slave            bus,
   input  wire logic [63:0] am_allow,
   input  wire logic        wr_protect,
   output logic             seq_active,
   output logic [31:0]      seq_addr
);
   typedef enum logic [2:0] {
      VS_IDLE = 3'b001,
      VS_RESP = 3'b010,
      VS_DROP = 3'b100
   } vdtb_sst_t;

   vdtb_sst_t   st_q;
   logic [31:0] mem_q [0:(1<<MEM_AW)-1];
   logic [31:0] full_a;
   logic [31:0] ctr_q;
   logic [31:0] eff_a;
   logic [1:0]  rng;
   logic        owns;
   logic        legal;
   logic [1:0]  size;
   logic        strobes;
   logic [MEM_AW-1:0] widx;

   // ----------------------------------------------------------
   // Decode
   // ----------------------------------------------------------
   assign strobes = !bus.as_n && (!bus.ds0_n || !bus.ds1_n);         // see R14
   assign rng     = vdtb_pkg::vdtb_am_range(bus.am);
   assign full_a  = {bus.addr, 1'b0} | {31'h0, bus.ds1_n};          // see R12
   assign eff_a   = (vdtb_pkg::vdtb_am_seq(bus.am) && seq_active) ? ctr_q : full_a; // see R21

   always_comb begin
      size = vdtb_pkg::SZ_BYTE;
      if (!bus.lword_n) begin
         size = vdtb_pkg::SZ_LONG;
      end else if (!bus.ds0_n && !bus.ds1_n) begin
         size = vdtb_pkg::SZ_WORD;
      end
   end

   always_comb begin
      owns = 1'b0;
      case (rng)                                                     // see R22
         vdtb_pkg::AW_A16: owns = (full_a[vdtb_pkg::A16_MSB:MEM_AW+2] == BASE[vdtb_pkg::A16_MSB:MEM_AW+2]);
         vdtb_pkg::AW_A24: owns = (AW != vdtb_pkg::AW_A16) &&
                                  (full_a[vdtb_pkg::A24_MSB:MEM_AW+2] == BASE[vdtb_pkg::A24_MSB:MEM_AW+2]);
         default:          owns = (AW == vdtb_pkg::AW_A32) &&                   // see R7
                                  (full_a[vdtb_pkg::A32_MSB:MEM_AW+2] == BASE[vdtb_pkg::A32_MSB:MEM_AW+2]);
      endcase
      if (AW == vdtb_pkg::AW_A16 && rng != vdtb_pkg::AW_A16) begin
         owns = 1'b0;                                                // see R6
      end
      if (!am_allow[bus.am]) begin
         owns = 1'b0;                                                // see R20
      end
      if (vdtb_pkg::vdtb_am_seq(bus.am) && !SEQ_EN) begin
         owns = 1'b0;                                                // see R9
      end
   end

   always_comb begin
      legal = 1'b1;
      if (DW == vdtb_pkg::DW_D8 && size != vdtb_pkg::SZ_BYTE) begin
         legal = 1'b0;                                               // see R1
      end
      if (DW == vdtb_pkg::DW_D16 && size == vdtb_pkg::SZ_LONG) begin
         legal = 1'b0;                                               // see R3
      end
      if (size == vdtb_pkg::SZ_LONG && full_a[1]) begin
         legal = 1'b0;                                               // see R4
      end
      if (!bus.write_n && wr_protect) begin
         legal = 1'b0;                                               // see R15
      end
   end

   assign widx = eff_a[MEM_AW+1:2];

   // ----------------------------------------------------------
   // Handshake
   // ----------------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q          <= VS_IDLE;
         bus.dtack_oe  <= 1'b0;
         bus.berr_oe   <= 1'b0;
         bus.s_data_oe <= 1'b0;
      end else begin
         case (st_q)
            VS_IDLE: begin
               if (strobes && owns) begin                            // see R15
                  st_q <= VS_RESP;
                  if (legal) begin
                     bus.s_data_oe <= bus.write_n;                   // see R14
                     bus.dtack_oe  <= 1'b1;                          // see R10
                  end else begin
                     bus.berr_oe   <= 1'b1;                          // see R15
                  end
               end
            end
            VS_RESP: begin
               if (bus.ds0_n && bus.ds1_n) begin
                  bus.s_data_oe <= 1'b0;                             // see R17
                  st_q          <= VS_DROP;
               end
            end
            VS_DROP: begin
               bus.dtack_oe <= 1'b0;                                 // see R17
               bus.berr_oe  <= 1'b0;
               st_q         <= VS_IDLE;
            end
            default: st_q <= VS_IDLE;
         endcase
      end
   end

   assign bus.dtack_n_o = 1'b0;
   assign bus.berr_n_o  = 1'b0;

   // ----------------------------------------------------------
   // Read data and memory write
   // ----------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (st_q == VS_IDLE && strobes && owns && legal) begin
         if (bus.write_n) begin
            if (size == vdtb_pkg::SZ_LONG) begin
               bus.s_data_o <= mem_q[widx];                          // see R14
            end else if (eff_a[1]) begin
               bus.s_data_o <= {16'h0000, mem_q[widx][31:16]};       // see R3
            end else begin
               bus.s_data_o <= {16'h0000, mem_q[widx][15:0]};
            end
         end else begin
            if (size == vdtb_pkg::SZ_LONG) begin
               mem_q[widx] <= bus.data_i;                            // see R4
            end else if (eff_a[1]) begin
               if (!bus.ds1_n) mem_q[widx][31:24] <= bus.data_i[15:8];
               if (!bus.ds0_n) mem_q[widx][23:16] <= bus.data_i[7:0];
            end else begin
               if (!bus.ds1_n) mem_q[widx][15:8]  <= bus.data_i[15:8];
               if (!bus.ds0_n) mem_q[widx][7:0]   <= bus.data_i[7:0];
            end
         end
      end
   end

   // ----------------------------------------------------------
   // Sequential counter
   // ----------------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ctr_q      <= 32'h0000_0000;
         seq_active <= 1'b0;
      end else if (st_q == VS_IDLE && strobes && owns) begin
         if (vdtb_pkg::vdtb_am_seq(bus.am) && !seq_active) begin
            seq_active <= 1'b1;                                      // see R19
            ctr_q      <= full_a;
         end
         if (vdtb_pkg::vdtb_am_seq(bus.am) && legal) begin
            if (size == vdtb_pkg::SZ_LONG) begin
               ctr_q <= eff_a + vdtb_pkg::STEP_LONG;                 // see R19
            end else if (size == vdtb_pkg::SZ_WORD) begin
               ctr_q <= eff_a + vdtb_pkg::STEP_WORD;
            end else if (!bus.ds0_n) begin
               ctr_q <= eff_a + vdtb_pkg::STEP_BYTE;
            end else begin
               ctr_q <= eff_a;
            end
         end
      end else if (bus.as_n && !vdtb_pkg::vdtb_am_seq(bus.am)) begin
         seq_active <= 1'b0;
         ctr_q      <= 32'h0000_0000;
      end
   end

   assign seq_addr = ctr_q;
endmodule : vdtb_slave
`default_nettype wire

// ===== hw/vdtb_master.sv
/*
 Master end of the data transfer bus with its own time-out, ordered over
 classic Wishbone registers. Assumes bus inputs synchronous to sys_clk.
*/
// Local design decisions: the Wishbone slave port and the register addresses.
`default_nettype none
module vdtb_master #(
   parameter logic [1:0] DW      = vdtb_pkg::DW_D32,
   parameter logic [1:0] AW      = vdtb_pkg::AW_A24,
   parameter logic       SEQ_EN  = 1'b1,
   parameter int         BTO_CYC = vdtb_pkg::BTO_CYC_DEF
) (
   input  wire logic        sys_clk,
   input  wire logic        sys_rst,
   vdtb_if.master           bus,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [3:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o
);
   // Register word offsets (byte address = 4 * index)
   localparam logic [3:0] REG_ADDR = 4'h0;
   localparam logic [3:0] REG_CTRL = 4'h1;
   localparam logic [3:0] REG_WDAT = 4'h2;
   localparam logic [3:0] REG_RDAT = 4'h3;
   localparam logic [3:0] REG_STAT = 4'h4;

   typedef enum logic [3:0] {
      VM_IDLE  = 4'b0001,
      VM_SETUP = 4'b0010,
      VM_WAIT  = 4'b0100,
      VM_END   = 4'b1000
   } vdtb_mst_t;

   vdtb_mst_t   st_q;
   logic [31:0] addr_q;
   logic [31:0] wdat_q;
   logic [31:0] rdat_q;
   logic [5:0]  am_q;
   logic [1:0]  size_q;
   logic        rd_q;
   logic        go;
   logic        busy_q;
   logic        done_q;
   logic        berr_q;
   logic        bto_q;
   logic [vdtb_pkg::BTO_CW-1:0] cnt_q;
   logic [5:0]  am_ok;
   logic        acc;
   logic        wr;
   logic        go_q;

   // Writes land at the edge where the bus master samples ack
   assign acc = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;
   assign go  = wr && wb_adr_i == REG_CTRL && wb_sel_i[0] && wb_dat_i[31] && st_q == VM_IDLE;

   // Clamp modifier to the built address range
   always_comb begin
      am_ok = wb_dat_i[5:0];
      if (AW == vdtb_pkg::AW_A16 && vdtb_pkg::vdtb_am_range(am_ok) != vdtb_pkg::AW_A16) begin
         am_ok = vdtb_pkg::AM_SHORT_NP;                              // see R5
      end
      if (AW == vdtb_pkg::AW_A24 && vdtb_pkg::vdtb_am_range(am_ok) == vdtb_pkg::AW_A32) begin
         am_ok = vdtb_pkg::AM_STD_NP_DATA;                           // see R7
      end
      if (!SEQ_EN && vdtb_pkg::vdtb_am_seq(am_ok)) begin
         am_ok = vdtb_pkg::AM_STD_NP_DATA;                           // see R9
      end
   end

   // ----------------------------------------------------------
   // Wishbone slave
   // ----------------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         addr_q   <= 32'h0000_0000;
         wdat_q   <= 32'h0000_0000;
         am_q     <= vdtb_pkg::AM_STD_NP_DATA;
         size_q   <= vdtb_pkg::SZ_BYTE;
         rd_q     <= 1'b1;
         go_q     <= 1'b0;
      end else begin
         wb_ack_o <= acc;
         go_q     <= go;
         if (acc && !wb_we_i) begin
            case (wb_adr_i)
               REG_ADDR: wb_dat_o <= addr_q;
               REG_CTRL: wb_dat_o <= {22'h0, size_q, rd_q, 1'b0, am_q};
               REG_WDAT: wb_dat_o <= wdat_q;
               REG_RDAT: wb_dat_o <= rdat_q;
               REG_STAT: wb_dat_o <= {28'h0000000, bto_q, berr_q, done_q, busy_q};
               default:  wb_dat_o <= 32'h0000_0000;
            endcase
         end
         if (wr && st_q == VM_IDLE) begin
            if (wb_adr_i == REG_ADDR && wb_sel_i == 4'hF) addr_q <= wb_dat_i;
            if (wb_adr_i == REG_WDAT && wb_sel_i == 4'hF) wdat_q <= wb_dat_i;
            if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
               am_q   <= am_ok;                                      // see R11
               rd_q   <= wb_dat_i[7];
               size_q <= wb_dat_i[9:8];
               if (DW != vdtb_pkg::DW_D32 && wb_dat_i[9:8] == vdtb_pkg::SZ_LONG) begin
                  size_q <= vdtb_pkg::SZ_WORD;                       // see R3
               end
               if (DW == vdtb_pkg::DW_D8) begin
                  size_q <= vdtb_pkg::SZ_BYTE;                       // see R2
               end
            end
         end
      end
   end

   // ----------------------------------------------------------
   // Bus cycle
   // ----------------------------------------------------------
   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q          <= VM_IDLE;
         bus.as_n      <= 1'b1;
         bus.ds0_n     <= 1'b1;
         bus.ds1_n     <= 1'b1;
         bus.lword_n   <= 1'b1;
         bus.write_n   <= 1'b1;
         bus.addr      <= 31'h00000000;
         bus.am        <= 6'h00;
         bus.m_data_o  <= 32'h0000_0000;
         bus.m_data_oe <= 1'b0;
         rdat_q        <= 32'h0000_0000;
         busy_q        <= 1'b0;
         done_q        <= 1'b0;
         berr_q        <= 1'b0;
         bto_q         <= 1'b0;
         cnt_q         <= '0;
      end else begin
         case (st_q)
            VM_IDLE: begin
               if (go_q) begin
                  busy_q   <= 1'b1;
                  done_q   <= 1'b0;
                  berr_q   <= 1'b0;
                  bto_q    <= 1'b0;
                  st_q     <= VM_SETUP;
                  bus.am   <= am_q;                                  // see R13
                  bus.addr <= (AW == vdtb_pkg::AW_A16) ? {16'h0000, addr_q[vdtb_pkg::A16_MSB:1]} :
                              (AW == vdtb_pkg::AW_A24) ? {8'h00, addr_q[vdtb_pkg::A24_MSB:1]} :
                              addr_q[vdtb_pkg::A32_MSB:1];           // see R12
                  bus.write_n   <= rd_q;
                  bus.lword_n   <= !(size_q == vdtb_pkg::SZ_LONG);
                  bus.m_data_oe <= !rd_q;
                  bus.m_data_o  <= (size_q == vdtb_pkg::SZ_BYTE) ? {16'h0000, wdat_q[7:0], wdat_q[7:0]} : wdat_q;
               end
            end
            VM_SETUP: begin
               bus.as_n  <= 1'b0;                                    // see R13
               bus.ds0_n <= (size_q == vdtb_pkg::SZ_BYTE) && !addr_q[0];
               bus.ds1_n <= (size_q == vdtb_pkg::SZ_BYTE) && addr_q[0];
               cnt_q     <= '0;
               st_q      <= VM_WAIT;
            end
            VM_WAIT: begin
               cnt_q <= cnt_q + 1'b1;                                // see R23
               if (!bus.dtack_n) begin
                  if (rd_q) begin
                     rdat_q <= (size_q == vdtb_pkg::SZ_LONG) ? bus.data_i :
                               (size_q == vdtb_pkg::SZ_WORD) ? {16'h0000, bus.data_i[15:0]} :
                               {24'h000000, addr_q[0] ? bus.data_i[7:0] : bus.data_i[15:8]}; // see R16
                  end
                  st_q <= VM_END;
               end else if (!bus.berr_n || cnt_q >= BTO_CYC[vdtb_pkg::BTO_CW-1:0]) begin
                  berr_q <= 1'b1;                                    // see R18
                  bto_q  <= bus.berr_n;                              // see R8
                  st_q   <= VM_END;
               end
               if (!bus.dtack_n || !bus.berr_n || cnt_q >= BTO_CYC[vdtb_pkg::BTO_CW-1:0]) begin
                  bus.as_n      <= 1'b1;                             // see R16
                  bus.ds0_n     <= 1'b1;
                  bus.ds1_n     <= 1'b1;
                  bus.m_data_oe <= 1'b0;
               end
            end
            VM_END: begin
               if (bus.dtack_n && bus.berr_n) begin                  // see R10
                  busy_q <= 1'b0;
                  done_q <= 1'b1;
                  st_q   <= VM_IDLE;
               end
            end
            default: st_q <= VM_IDLE;
         endcase
      end
   end
endmodule : vdtb_master
`default_nettype wire

// ===== sim/vdtb_sva.sv
/* Checker of the handshake between the master and slave ends.
   Assumes all signals are synchronous to sys_clk. */
`default_nettype none
module vdtb_sva (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic [31:1] addr,
   input wire logic [5:0]  am,
   input wire logic        as_n,
   input wire logic        ds0_n,
   input wire logic        ds1_n,
   input wire logic        s_data_oe,
   input wire logic        dtack_oe,
   input wire logic        berr_oe
);
   // ------
   // Checks
   // ------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_addr_held: assert property (!as_n |-> $stable(addr) && $stable(am))
      else $error("address moved in cycle");
   a_addr_range: assert property (!as_n |-> addr[31:24] == 8'h00)
      else $error("address above 23 bits");
   a_am_standard: assert property (!as_n |-> am[5:4] == 2'h3)
      else $error("modifier not standard");
   a_ack_on_strobe: assert property ($rose(dtack_oe) |-> !as_n && !(ds0_n && ds1_n))
      else $error("ack without strobes");
   a_one_response: assert property (!(dtack_oe && berr_oe))
      else $error("ack and error together");
   a_strobe_end: assert property ($rose(dtack_oe) || $rose(berr_oe) |=> as_n && ds0_n && ds1_n)
      else $error("strobes not released");
   a_resp_held: assert property ((dtack_oe || berr_oe) && !(ds0_n && ds1_n) |=> dtack_oe || berr_oe)
      else $error("response dropped early");
   a_data_first: assert property ($fell(dtack_oe) |-> !s_data_oe && !$past(s_data_oe))
      else $error("data held past ack");
   a_cycle_bound: assert property ($fell(as_n) |-> ##[1:30] as_n)
      else $error("cycle not ended");
   c_ack: cover property ($rose(dtack_oe));
   c_berr: cover property ($rose(berr_oe));
   c_wait: cover property ((!as_n && !dtack_oe && !berr_oe)[*8]);
endmodule : vdtb_sva
`default_nettype wire

// ===== sim/test_vme_data_transfer_bus_handshake.sv
/* Bench joining both ends through vdtb_if, ordering cycles over Wishbone.
   Assumes the master's register map and status layout. */
`default_nettype none
module test_vme_data_transfer_bus_handshake;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [5:0] AMD = 6'h39;
   logic        sys_clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, wr_protect, seq_active;
   logic [3:0]  wb_adr;
   logic [31:0] wb_wdat, wb_rdat, seq_addr, st, rd, a, d;
   logic [63:0] am_allow;
   logic [5:0]  codes [4];
   int          seed, n_fail, n_checks;
   // -----------
   // Bus and ends
   // -----------
   vdtb_if bif ();
   assign bif.data_i = bif.m_data_oe ? bif.m_data_o : (bif.s_data_oe ? bif.s_data_o : 32'hFFFF_FFFF);
   assign bif.dtack_n = bif.dtack_oe ? bif.dtack_n_o : 1'b1;
   assign bif.berr_n = bif.berr_oe ? bif.berr_n_o : 1'b1;
   always #25 sys_clk = ~sys_clk;
   vdtb_master #(.BTO_CYC(20)) vdtb_master_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bif.master),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hF),
      .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack));
   vdtb_slave vdtb_slave_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bif.slave), .am_allow(am_allow),
      .wr_protect(wr_protect), .seq_active(seq_active), .seq_addr(seq_addr));
   vdtb_sva vdtb_sva_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .addr(bif.addr), .am(bif.am), .as_n(bif.as_n),
      .ds0_n(bif.ds0_n), .ds1_n(bif.ds1_n), .s_data_oe(bif.s_data_oe), .dtack_oe(bif.dtack_oe),
      .berr_oe(bif.berr_oe));
   // -----
   // Tasks
   // -----
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, output logic [31:0] q);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_wdat <= dat;
      @(posedge sys_clk);
      while (wb_ack !== 1'b1) @(posedge sys_clk);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge sys_clk);
   endtask : wb
   task automatic op(input logic [31:0] ad, input logic [5:0] am, input logic rdn, input logic [1:0] sz,
                     input logic [31:0] wd, output logic [31:0] s, output logic [31:0] q);
      logic [31:0] t;
      wb(1'b1, 4'h0, ad, t);
      wb(1'b1, 4'h2, wd, t);
      wb(1'b1, 4'h1, {1'b1, 21'h0, sz, rdn, 1'b0, am}, t);
      s = 32'h1;
      for (int i = 0; i < 60 && s[0] !== 1'b0; i++) wb(1'b0, 4'h4, 32'h0, s);
      wb(1'b0, 4'h3, 32'h0, q);
   endtask : op
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   function automatic logic [31:0] exp_st(input logic berr, input logic tmo);
      return {28'h0, tmo, berr, 2'b10};
   endfunction : exp_st
   // Of the sequential codes, only the standard ones survive the A24 master
   function automatic logic seq_hit(input logic [5:0] c);
      return (c == 6'h3F) || (c == 6'h3B);
   endfunction : seq_hit
   task automatic complete_run();
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      complete_run();
   end
   initial begin
      sys_clk = 1'b0;
      sys_rst = 1'b1;
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 4'h0;
      wb_wdat = 32'h0;
      am_allow = {64{1'b1}};
      wr_protect = 1'b0;
      codes = '{6'h3F, 6'h3B, 6'h0F, 6'h0B};
      seed = 36;
      n_fail = 0;
      n_checks = 0;
      repeat (10) @(posedge sys_clk);
      sys_rst <= 1'b0;
      @(posedge sys_clk);
      for (int k = 0; k < 8; k++) begin
         a = $random(seed) & 32'h0000_03FC;
         d = $random(seed);
         op(a, AMD, 1'b0, 2'h2, d, st, rd);
         chk(st, exp_st(1'b0, 1'b0));
         op(a, AMD, 1'b1, 2'h2, 32'h0, st, rd);
         chk(rd, d);
      end
      $display("Test longword done");
      op(32'h10, AMD, 1'b0, 2'h0, 32'hA5, st, rd);
      op(32'h11, AMD, 1'b0, 2'h0, 32'h5A, st, rd);
      op(32'h10, AMD, 1'b1, 2'h0, 32'h0, st, rd);
      chk(rd, 32'hA5);
      op(32'h11, AMD, 1'b1, 2'h0, 32'h0, st, rd);
      chk(rd, 32'h5A);
      op(32'h12, AMD, 1'b0, 2'h1, 32'hBEEF, st, rd);
      op(32'h12, AMD, 1'b1, 2'h1, 32'h0, st, rd);
      chk(rd, 32'hBEEF);
      $display("Test byte and word done");
      wr_protect <= 1'b1;
      op(32'h10, AMD, 1'b0, 2'h0, 32'h0, st, rd);
      chk(st, exp_st(1'b1, 1'b0));
      op(32'h10, AMD, 1'b1, 2'h0, 32'h0, st, rd);
      chk(rd, 32'hA5);
      wr_protect <= 1'b0;
      op(32'h12, AMD, 1'b1, 2'h2, 32'h0, st, rd);
      chk(st, exp_st(1'b1, 1'b0));
      am_allow <= ~(64'h1 << 6'h39);
      op(32'h10, AMD, 1'b1, 2'h0, 32'h0, st, rd);
      chk(st, exp_st(1'b1, 1'b1));
      am_allow <= {64{1'b1}};
      op(32'h00F0_0000, AMD, 1'b1, 2'h2, 32'h0, st, rd);
      chk(st, exp_st(1'b1, 1'b1));
      $display("Test errors done");
      foreach (codes[j]) begin
         op(32'h20, codes[j], 1'b0, 2'h2, 32'h1, st, rd);
         d = $random(seed);
         op(32'h80, codes[j], 1'b0, 2'h2, d, st, rd);
         chk(seq_addr, seq_hit(codes[j]) ? 32'h28 : 32'h0);
         chk({31'h0, seq_active}, {31'h0, seq_hit(codes[j])});
         op(seq_hit(codes[j]) ? 32'h24 : 32'h80, AMD, 1'b1, 2'h2, 32'h0, st, rd);
         chk(rd, d);
      end
      $display("Test sequential done");
      wb(1'b0, 4'hF, 32'h0, rd);
      chk(rd, 32'h0);
      $display("Test unmapped read done");
      complete_run();
   end
endmodule : test_vme_data_transfer_bus_handshake
`default_nettype wire
